// ===== hw/serial_exchange_pkg.sv
// Purpose: Shared constants and types for the serial exchange unit
// Assumes: 200 MHz system clock, byte-wide transfers
// Notes:   Half-period counts are system clocks per serial clock phase
package serial_exchange_pkg;

  localparam int unsigned DATA_WIDTH   = 8;
  localparam int unsigned EDGE_TOTAL   = 2 * DATA_WIDTH;
  localparam int unsigned HALF_W       = 6;
  localparam int unsigned EDGE_W       = 5;
  localparam int unsigned BIT_W        = 4;
  localparam int unsigned SYNC_STAGES  = 2;

  // Rate codes and system clocks per serial half period
  localparam logic [1:0] RATE_DIV4     = 2'h0;
  localparam logic [1:0] RATE_DIV8     = 2'h1;
  localparam logic [1:0] RATE_DIV16    = 2'h2;
  localparam logic [1:0] RATE_DIV64    = 2'h3;
  localparam logic [HALF_W-1:0] HALF_DIV4  = 6'h02;
  localparam logic [HALF_W-1:0] HALF_DIV8  = 6'h04;
  localparam logic [HALF_W-1:0] HALF_DIV16 = 6'h08;
  localparam logic [HALF_W-1:0] HALF_DIV64 = 6'h20;

  localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;
  localparam logic [EDGE_W-1:0] EDGE_LAST  = 5'h10;
  localparam logic [BIT_W-1:0]  BIT_LAST   = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LEAD = 3'b010,
    ST_RUN  = 3'b100
  } master_state_type;

  typedef struct packed {
    logic       unit_enable;
    logic       master_select_bit;
    logic       clk_polarity;
    logic       clk_phase;
    logic       bit_order_select;
    logic [1:0] rate_select_field;
  } exchange_control_type;

  typedef struct packed {
    logic transfer_complete_flag;
    logic write_collision_flag;
    logic slave_overflow_flag;
  } exchange_status_type;

endpackage

// ===== hw/sync_stage.sv
// Purpose: Two-flop synchroniser for asynchronous pin inputs
// Assumes: Single system clock domain on the output side
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module sync_stage #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_value_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
          meta[i]     <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta[i]     <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate

  // Reset value port kept for level idle matching by caller
  logic unused_reset_value;
  assign unused_reset_value = ^reset_value_in;

endmodule

// ===== hw/serial_peripheral_exchange.sv
// Purpose: Byte-wide synchronous serial exchange unit, master or slave
// Assumes: Control bits and data register access arrive as plain ports
// Notes:   Shift register doubles as the data register
// Function
// - Master drives serial clock, slave receives it
// - Master emits eight clock pulses, idle otherwise
// - Slave ignores clock while select is high
// - Shift on one edge, sample on other
// - Master drives MOSI; slave drives MISO
// - Slave drives MISO only while unit enabled
// - Phase 0: polarity sets idle and edges
// - Phase 0 master: first bit before edge
// - Phase 0 slave: write with select low collides
// - Phase 1: polarity sets idle and edges
// - Phase 1 master: first bit on write, before first edge
// - Phase 1 slave: write allowed when not busy
// - Complete flag set after eighth shift cycle
// - Write during transfer collides, data untouched
// - One shift register exchanges both directions
// - Interrupt on complete flag rising edge
// - Idle write loads shift register directly
// - Slave unread byte overwritten sets overflow
// - Collision detection in master and slave
// - Status read then data access clears flags
// - Bit order select chooses MSB or LSB first
// - Master rate divides by 4/8/16/64
`timescale 1ns/1ps
module serial_peripheral_exchange
  import serial_exchange_pkg::*;
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  resetn_in,
  input  wire exchange_control_type  control_in,
  input  wire logic                  data_write_in,
  input  wire logic [DATA_WIDTH-1:0] data_wdata_in,
  input  wire logic                  data_read_in,
  input  wire logic                  status_read_in,
  output logic [DATA_WIDTH-1:0]      shift_data_register_out,
  output exchange_status_type        exchange_status_register_out,
  output logic                       busy_out,
  output logic                       serial_irq_out,
  input  wire logic                  sclk_in,
  output logic                       sclk_out,
  output logic                       sclk_oe_n_out,
  input  wire logic                  mosi_in,
  output logic                       mosi_out,
  output logic                       mosi_oe_n_out,
  input  wire logic                  miso_in,
  output logic                       miso_out,
  output logic                       miso_oe_n_out,
  input  wire logic                  ss_n_in
);

  // Synchronised pins
  logic [3:0] pins_sync;
  logic       sclk_s;
  logic       ss_n_s;
  logic       mosi_s;
  logic       miso_s;

  sync_stage #(
    .WIDTH          (4)
  ) u_sync (
    .sys_clk_in     (sys_clk_in),
    .resetn_in      (resetn_in),
    .async_in       ({sclk_in, ~ss_n_in, mosi_in, miso_in}),
    .reset_value_in (4'h0),
    .sync_out       (pins_sync)
  );

  assign sclk_s = pins_sync[3];
  assign ss_n_s = ~pins_sync[2];
  assign mosi_s = pins_sync[1];
  assign miso_s = pins_sync[0];

  // State
  master_state_type          state;
  master_state_type          next_state;
  logic [DATA_WIDTH-1:0]     shreg;
  logic [DATA_WIDTH-1:0]     next_shreg;
  logic                      out_bit;
  logic                      next_out_bit;
  logic                      sclk_q;
  logic                      next_sclk_q;
  logic [HALF_W-1:0]         half_cnt;
  logic [HALF_W-1:0]         next_half_cnt;
  logic [EDGE_W-1:0]         edge_cnt;
  logic [EDGE_W-1:0]         next_edge_cnt;
  logic [BIT_W-1:0]          bit_cnt;
  logic [BIT_W-1:0]          next_bit_cnt;
  logic                      sclk_d;
  logic                      ss_n_d;
  logic                      armed;
  logic                      next_armed;
  exchange_status_type       flags;
  exchange_status_type       next_flags;
  logic                      next_irq;
  logic [1:0]                samp_pipe;
  logic [1:0]                next_samp_pipe;
  logic [1:0]                last_pipe;
  logic [1:0]                next_last_pipe;

  // Combinational helpers
  logic                      is_master;
  logic                      master_busy;
  logic                      slave_busy;
  logic                      busy;
  logic                      tx_bit;
  logic                      rx_bit;
  logic [DATA_WIDTH-1:0]     shifted;
  logic [HALF_W-1:0]         half_reload;
  logic                      m_edge;
  logic                      m_sample;
  logic                      s_edge;
  logic                      s_sample;
  logic                      do_sample;
  logic                      do_drive;
  logic                      done;
  logic                      collide;
  logic                      load;
  logic                      clear_flags;

  assign is_master   = control_in.master_select_bit;
  assign master_busy = (state != ST_IDLE) || (samp_pipe != '0);
  assign slave_busy  = (bit_cnt != '0);
  assign busy        = is_master ? master_busy : slave_busy;

  // Bit order: MSB first when 0, LSB first when 1
  assign tx_bit  = control_in.bit_order_select ? shreg[0]
                                               : shreg[DATA_WIDTH-1];
  assign rx_bit  = is_master ? miso_s : mosi_s;
  assign shifted = control_in.bit_order_select
                 ? {rx_bit, shreg[DATA_WIDTH-1:1]}
                 : {shreg[DATA_WIDTH-2:0], rx_bit};

  always_comb begin
    case (control_in.rate_select_field)
      RATE_DIV4:  half_reload = HALF_DIV4;
      RATE_DIV8:  half_reload = HALF_DIV8;
      RATE_DIV16: half_reload = HALF_DIV16;
      RATE_DIV64: half_reload = HALF_DIV64;
      default:    half_reload = HALF_DIV4;
    endcase
  end

  // Master edges: even count is a leading edge
  assign m_edge   = (state == ST_RUN || state == ST_LEAD)
                  && (half_cnt == '0);
  assign m_sample = m_edge
                  && (~edge_cnt[0] ^ control_in.clk_phase);

  // MISO is taken once it has crossed the synchroniser
  assign next_samp_pipe = {samp_pipe[0], m_sample};
  assign next_last_pipe = {last_pipe[0],
                           m_sample && (edge_cnt == EDGE_LAST - 5'h01)};

  // Slave edges seen only while selected
  assign s_edge   = !is_master && !ss_n_s && (sclk_s != sclk_d);
  assign s_sample = s_edge
                  && ((sclk_s != control_in.clk_polarity)
                      ^ control_in.clk_phase);

  assign do_sample = is_master ? samp_pipe[1] : s_sample;
  assign do_drive  = is_master ? ((state == ST_RUN) && m_edge && !m_sample)
                               : (s_edge && !s_sample);

  assign done = is_master
              ? (control_in.clk_phase ? (samp_pipe[1] && last_pipe[1])
                 : ((state == ST_RUN) && m_edge
                    && (edge_cnt == EDGE_LAST - 5'h01)))
              : (s_sample && (bit_cnt == BIT_LAST - 4'h1));

  // Collision on write while busy, or phase 0 slave with select low
  assign collide = data_write_in
                 && (busy
                     || (!is_master && !control_in.clk_phase
                         && !ss_n_s));
  assign load    = data_write_in && !collide;

  assign clear_flags = armed && (data_read_in || data_write_in);

  always_comb begin
    next_state    = state;
    next_shreg    = shreg;
    next_out_bit  = out_bit;
    next_sclk_q   = sclk_q;
    next_half_cnt = half_cnt;
    next_edge_cnt = edge_cnt;
    next_bit_cnt  = bit_cnt;
    next_armed    = armed;
    next_flags    = flags;

    // Master clock generator
    case (state)
      ST_IDLE: begin
        next_sclk_q   = control_in.clk_polarity;
        next_edge_cnt = '0;
        if (load && is_master && control_in.unit_enable) begin
          next_state    = ST_LEAD;
          next_half_cnt = half_reload - 6'h01;
        end
      end
      ST_LEAD: begin
        if (half_cnt == '0) begin
          next_state    = ST_RUN;
          next_half_cnt = half_reload - 6'h01;
          next_sclk_q   = ~sclk_q;
          next_edge_cnt = 5'h01;
        end else begin
          next_half_cnt = half_cnt - 6'h01;
        end
      end
      ST_RUN: begin
        if (half_cnt == '0) begin
          next_half_cnt = half_reload - 6'h01;
          next_sclk_q   = ~sclk_q;
          next_edge_cnt = edge_cnt + 5'h01;
          if (edge_cnt == EDGE_LAST - 5'h01) begin
            next_state  = ST_IDLE;
          end
        end else begin
          next_half_cnt = half_cnt - 6'h01;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // Shift register and data line
    if (load) begin
      next_shreg   = data_wdata_in;
      next_out_bit = control_in.bit_order_select ? data_wdata_in[0]
                     : data_wdata_in[DATA_WIDTH-1];
    end else begin
      if (do_sample) begin
        next_shreg = shifted;
      end
      if (do_drive) begin
        next_out_bit = control_in.bit_order_select ? next_shreg[0]
                       : next_shreg[DATA_WIDTH-1];
      end
    end

    // Phase 0 slave presents first bit as select falls
    if (!is_master && !control_in.clk_phase && !ss_n_s && ss_n_d) begin
      next_out_bit = tx_bit;
    end

    // Slave bit counter, dropped if select rises mid byte
    if (is_master || ss_n_s) begin
      next_bit_cnt = '0;
    end else if (s_sample) begin
      next_bit_cnt = done ? '0 : bit_cnt + 4'h1;
    end

    // Status flags: complete and collision set win over the read-then-access clear
    if (status_read_in) begin
      next_armed = 1'b1;
    end else if (data_read_in || data_write_in) begin
      next_armed = 1'b0;
    end
    if (clear_flags) begin
      next_flags = '0;
    end
    if (is_master) begin
      next_flags.slave_overflow_flag = 1'b0;
    end
    if (done) begin
      next_flags.transfer_complete_flag = 1'b1;
      if (!is_master && flags.transfer_complete_flag && !clear_flags) begin
        next_flags.slave_overflow_flag = 1'b1;
      end
    end
    if (collide) begin
      next_flags.write_collision_flag = 1'b1;
    end
  end

  assign next_irq = next_flags.transfer_complete_flag
                  && !flags.transfer_complete_flag;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state    <= ST_IDLE;
      shreg    <= DATA_RESET;
      out_bit  <= 1'b0;
      sclk_q   <= 1'b0;
      half_cnt <= '0;
      edge_cnt <= '0;
      bit_cnt  <= '0;
      sclk_d   <= 1'b0;
      ss_n_d   <= 1'b1;
      armed    <= 1'b0;
      flags    <= '0;
      samp_pipe <= '0;
      last_pipe <= '0;
    end else begin
      state    <= next_state;
      shreg    <= next_shreg;
      out_bit  <= next_out_bit;
      sclk_q   <= next_sclk_q;
      half_cnt <= next_half_cnt;
      edge_cnt <= next_edge_cnt;
      bit_cnt  <= next_bit_cnt;
      sclk_d   <= sclk_s;
      ss_n_d   <= ss_n_s;
      armed    <= next_armed;
      flags    <= next_flags;
      samp_pipe <= next_samp_pipe;
      last_pipe <= next_last_pipe;
    end
  end

  // Output registers
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      shift_data_register_out      <= DATA_RESET;
      exchange_status_register_out <= '0;
      busy_out                     <= 1'b0;
      serial_irq_out               <= 1'b0;
      sclk_out                     <= 1'b0;
      sclk_oe_n_out                <= 1'b1;
      mosi_out                     <= 1'b0;
      mosi_oe_n_out                <= 1'b1;
      miso_out                     <= 1'b0;
      miso_oe_n_out                <= 1'b1;
    end else begin
      shift_data_register_out      <= next_shreg;
      exchange_status_register_out <= next_flags;
      busy_out                     <= (next_state != ST_IDLE)
                                      || (next_samp_pipe != '0)
                                      || (next_bit_cnt != '0);
      serial_irq_out               <= next_irq;
      sclk_out                     <= next_sclk_q;
      sclk_oe_n_out                <= ~(is_master
                                        && control_in.unit_enable);
      mosi_out                     <= next_out_bit;
      mosi_oe_n_out                <= ~(is_master
                                        && control_in.unit_enable);
      miso_out                     <= next_out_bit;
      miso_oe_n_out                <= ~(!is_master
                                        && control_in.unit_enable);
    end
  end

endmodule

// ===== verif/serial_exchange_monitor.sv
// Purpose: Port checks on the serial exchange unit
// Assumes: One clock, synchronous active-low reset
// Notes:   Helper counters track serial clock toggles
`timescale 1ns/1ps
module serial_exchange_monitor
  import serial_exchange_pkg::*;
(
  input wire logic                  sys_clk_in,
  input wire logic                  resetn_in,
  input wire exchange_control_type  control_in,
  input wire logic                  data_write_in,
  input wire logic [DATA_WIDTH-1:0] data_wdata_in,
  input wire logic [DATA_WIDTH-1:0] shift_data_register_out,
  input wire exchange_status_type   exchange_status_register_out,
  input wire logic                  busy_out,
  input wire logic                  serial_irq_out,
  input wire logic                  sclk_out,
  input wire logic                  sclk_oe_n_out,
  input wire logic                  mosi_oe_n_out,
  input wire logic                  miso_oe_n_out,
  input wire logic                  ss_n_in
);
  logic              sclk_d, next_sclk_d;
  logic [HALF_W-1:0] half, gap, next_gap;
  logic [EDGE_W-1:0] tog, next_tog;
  wire ms = control_in.master_select_bit;
  wire done = exchange_status_register_out.transfer_complete_flag;
  always_comb begin
    case (control_in.rate_select_field)
      RATE_DIV4: half = HALF_DIV4;
      RATE_DIV8: half = HALF_DIV8;
      RATE_DIV16: half = HALF_DIV16;
      default: half = HALF_DIV64;
    endcase
    next_sclk_d = sclk_out;
    next_gap = (sclk_out != sclk_d) ? 6'h00 : gap + 6'h01;
    next_tog = tog + ((sclk_out != sclk_d) ? 5'h01 : 5'h00);
    if (data_write_in && !busy_out)
      next_tog = 5'h00;
  end
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      sclk_d <= 1'b0;
      gap <= 6'h00;
      tog <= 5'h00;
    end else begin
      sclk_d <= next_sclk_d;
      gap <= next_gap;
      tog <= next_tog;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  sclk_drive_a: assert property ($past(resetn_in) |->
    sclk_oe_n_out == !($past(control_in.unit_enable) && $past(ms))
    && mosi_oe_n_out == sclk_oe_n_out) else $error("clock drive wrong");
  miso_drive_a: assert property ($past(resetn_in) |->
    miso_oe_n_out == !($past(control_in.unit_enable) && !$past(ms)))
    else $error("miso drive wrong");
  sclk_idle_a: assert property ($past(resetn_in) && ms
    && !busy_out && !$past(busy_out) && $stable(control_in)
    |-> sclk_out == control_in.clk_polarity) else $error("clock not idle");
  irq_edge_a: assert property (serial_irq_out == $rose(done))
    else $error("irq not on flag rise");
  write_load_a: assert property (data_write_in && !busy_out && ms
    && control_in.unit_enable |=> busy_out
    && shift_data_register_out == $past(data_wdata_in))
    else $error("idle write not loaded");
  collide_flag_a: assert property (data_write_in && busy_out
    |=> exchange_status_register_out.write_collision_flag)
    else $error("collision not flagged");
  half_period_a: assert property (ms && busy_out && $changed(sclk_out)
    && tog != 5'h00 |-> gap == half - 6'h01) else $error("bad clock rate");
  pulse_count_a: assert property ($rose(done) && ms
    |-> tog + ($changed(sclk_out) ? 5'h01 : 5'h00) == 5'h10)
    else $error("bad pulse count");
  unselected_quiet_a: assert property ((!ms && ss_n_in) [*6]
    |-> !$rose(done)) else $error("unselected slave took data");
  cover property ($rose(done) && ms);
  cover property ($rose(exchange_status_register_out.write_collision_flag));
  cover property ($rose(exchange_status_register_out.slave_overflow_flag));
endmodule

// ===== verif/serial_far_side.sv
// Purpose: Far side: slave to a master unit, master to a slave unit
// Assumes: Mode inputs mirror the unit's control bits
// Notes:   Master side is a timed task with its own half period
`timescale 1ns/1ps
module serial_far_side #(
  parameter int HALF_NS = 41
) (
  input  wire logic sclk_in,
  input  wire logic mosi_in,
  input  wire logic miso_in,
  input  wire logic cpol_in,
  input  wire logic cpha_in,
  input  wire logic lsb_in,
  input  wire logic slave_en_in,
  output logic      sclk_out,
  output logic      mosi_out,
  output logic      miso_out,
  output logic      ss_n_out
);
  logic [7:0] tx, got;
  int         n;
  function automatic int ix(input int k);
    return lsb_in ? k : 7 - k;
  endfunction
  initial begin
    {sclk_out, mosi_out, miso_out, ss_n_out} = 4'h1;
    {tx, got, n} = '0;
  end
  task automatic load(input logic [7:0] b);
    tx = b;
    n = 0;
    miso_out = b[ix(0)];
  endtask
  task automatic sel(input logic s);
    ss_n_out = !s;
  endtask
  // Slave: sample on leading edge for phase 0, trailing for phase 1
  always @(sclk_in) begin
    if (slave_en_in && ((sclk_in != cpol_in) ^ cpha_in)) begin
      got[ix(n)] = mosi_in;
      n = n + 1;
    end else if (slave_en_in && n < 8)
      miso_out = tx[ix(n)];
  end
  task automatic xfer(input logic [7:0] b, input logic s,
                      output logic [7:0] r);
    sclk_out = cpol_in;
    #HALF_NS;
    ss_n_out = !s;
    mosi_out = b[ix(0)];
    #HALF_NS;
    for (int k = 0; k < 8; k++) begin
      if (cpha_in)
        mosi_out = b[ix(k)];
      sclk_out = !cpol_in;
      if (!cpha_in)
        r[ix(k)] = miso_in;
      #HALF_NS;
      sclk_out = cpol_in;
      if (cpha_in)
        r[ix(k)] = miso_in;
      else if (k < 7)
        mosi_out = b[ix(k + 1)];
      #HALF_NS;
    end
    ss_n_out = 1'b1;
    mosi_out = !mosi_out;
  endtask
endmodule

// ===== verif/serial_peripheral_exchange_tb.sv
// Purpose: Self-checking bench for the serial exchange unit
// Assumes: Far-side model plays slave or master as needed
// Notes:   Inputs change by non-blocking assignment on rising edges
`timescale 1ns/1ps
module serial_peripheral_exchange_tb;
  import serial_exchange_pkg::*;
  logic                 sys_clk_in, resetn_in, wr, rd, srd, busy, irq;
  exchange_control_type control_in;
  exchange_status_type  st;
  logic [7:0]           wdata, shq, rx, b;
  logic                 got_irq, sclk_o, sclk_oe_n, mosi_o, mosi_oe_n;
  logic                 miso_o, miso_oe_n, f_sclk, f_mosi, f_miso, f_ss_n;
  int                   miscompares, n_compared;
  wire sclk_w = sclk_oe_n ? f_sclk : sclk_o;
  wire mosi_w = mosi_oe_n ? f_mosi : mosi_o;
  wire miso_w = miso_oe_n ? f_miso : miso_o;
  serial_peripheral_exchange dut (.sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in), .control_in(control_in), .data_write_in(wr),
    .data_wdata_in(wdata), .data_read_in(rd), .status_read_in(srd),
    .shift_data_register_out(shq), .exchange_status_register_out(st),
    .busy_out(busy), .serial_irq_out(irq), .sclk_in(sclk_w),
    .sclk_out(sclk_o), .sclk_oe_n_out(sclk_oe_n), .mosi_in(mosi_w),
    .mosi_out(mosi_o), .mosi_oe_n_out(mosi_oe_n), .miso_in(miso_w),
    .miso_out(miso_o), .miso_oe_n_out(miso_oe_n), .ss_n_in(f_ss_n));
  serial_far_side far (.sclk_in(sclk_w), .mosi_in(mosi_w),
    .miso_in(miso_w), .cpol_in(control_in.clk_polarity),
    .cpha_in(control_in.clk_phase), .lsb_in(control_in.bit_order_select),
    .slave_en_in(control_in.master_select_bit), .sclk_out(f_sclk),
    .mosi_out(f_mosi), .miso_out(f_miso), .ss_n_out(f_ss_n));
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: byte %h, want %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: bit %b, want %b", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic set_ctl(input exchange_control_type c);
    @(posedge sys_clk_in) control_in <= c;
    tick(3);
  endtask
  task automatic pulse_wr(input logic [7:0] v);
    @(posedge sys_clk_in) {wr, wdata} <= {1'b1, v};
    @(posedge sys_clk_in) wr <= 1'b0;
    #1;
  endtask
  task automatic clear_flags;
    @(posedge sys_clk_in) srd <= 1'b1;
    @(posedge sys_clk_in) {srd, rd} <= 2'b01;
    @(posedge sys_clk_in) rd <= 1'b0;
    #1;
  endtask
  task automatic wait_done;
    got_irq = 1'b0;
    for (int i = 0; i < 3000 && st.transfer_complete_flag !== 1'b1; i++) begin
      @(posedge sys_clk_in);
      #1;
      if (irq === 1'b1)
        got_irq = 1'b1;
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #100us;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    {resetn_in, control_in, wr, rd, srd, wdata} = '0;
    {miscompares, n_compared} = '0;
    tick(6);
    resetn_in <= 1'b1;
    tick(2);
    for (int r = 0; r < 4; r++) begin
      set_ctl({2'b11, r[0], r[1], r[0] ^ r[1], r[1:0]});
      b = 8'hA5 ^ 8'(r);
      far.load(~b);
      pulse_wr(b);
      if (!control_in.clk_phase)
        chk_bit(mosi_o, control_in.bit_order_select ? b[0] : b[7]);
      chk_bit(sclk_o, control_in.clk_polarity);
      wait_done;
      chk_bit(st.transfer_complete_flag, 1'b1);
      chk_bit(got_irq, 1'b1);
      chk_byte(shq, ~b);
      chk_byte(far.got, b);
      clear_flags;
      chk_bit(st.transfer_complete_flag, 1'b0);
    end
    set_ctl(7'b1100001);
    far.load(8'h81);
    pulse_wr(8'h5A);
    tick(4);
    pulse_wr(8'hFF);
    chk_bit(st.write_collision_flag, 1'b1);
    wait_done;
    chk_byte(shq, 8'h81);
    chk_byte(far.got, 8'h5A);
    clear_flags;
    chk_bit(st.write_collision_flag, 1'b0);
    set_ctl(7'b1000011);
    chk_bit(miso_oe_n, 1'b0);
    pulse_wr(8'hC3);
    far.xfer(8'h96, 1'b1, rx);
    wait_done;
    chk_bit(st.transfer_complete_flag, 1'b1);
    chk_byte(rx, 8'hC3);
    chk_byte(shq, 8'h96);
    far.xfer(8'h69, 1'b1, rx);
    chk_byte(rx, 8'h96);
    chk_bit(st.slave_overflow_flag, 1'b1);
    chk_byte(shq, 8'h69);
    clear_flags;
    far.xfer(8'h55, 1'b0, rx);
    chk_bit(st.transfer_complete_flag, 1'b0);
    chk_byte(shq, 8'h69);
    far.sel(1'b1);
    tick(4);
    pulse_wr(8'h11);
    chk_bit(st.write_collision_flag, 1'b1);
    chk_byte(shq, 8'h69);
    set_ctl(7'b1001000);
    clear_flags;
    pulse_wr(8'h22);
    chk_byte(shq, 8'h22);
    chk_bit(st.write_collision_flag, 1'b0);
    far.sel(1'b0);
    set_ctl(7'b0000000);
    chk_bit(miso_oe_n, 1'b1);
    tally_and_finish;
  end
endmodule
bind serial_peripheral_exchange serial_exchange_monitor mon (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .control_in(control_in),
  .data_write_in(data_write_in), .data_wdata_in(data_wdata_in),
  .shift_data_register_out(shift_data_register_out),
  .exchange_status_register_out(exchange_status_register_out),
  .busy_out(busy_out), .serial_irq_out(serial_irq_out),
  .sclk_out(sclk_out), .sclk_oe_n_out(sclk_oe_n_out),
  .mosi_oe_n_out(mosi_oe_n_out), .miso_oe_n_out(miso_oe_n_out),
  .ss_n_in(ss_n_in));
